/* core/lrcf_regs.vh */
// Constants for the link response and credit flow block
`ifndef LRCF_REGS_VH
`define LRCF_REGS_VH
// Buffer type indices
`define LRCF_BT_PCMD 3'd0
`define LRCF_BT_PDAT 3'd1
`define LRCF_BT_NCMD 3'd2
`define LRCF_BT_NDAT 3'd3
`define LRCF_BT_RCMD 3'd4
`define LRCF_BT_RDAT 3'd5
// Virtual channels
`define LRCF_VC_POSTED 2'd0
`define LRCF_VC_NONPOSTED 2'd1
`define LRCF_VC_RESPONSE 2'd2
// Request kinds
`define LRCF_REQ_DWORD_READ 2'd0
`define LRCF_REQ_BYTE_READ 2'd1
`define LRCF_REQ_ATOMIC 2'd2
`define LRCF_REQ_WRITE 2'd3
// Response command codes
`define LRCF_CMD_READ_RESP 6'h30
`define LRCF_CMD_TARGET_DONE 6'h33
`define LRCF_CMD_CREDIT_RET 6'h00
// Size values
`define LRCF_SIZE_BYTE_READ 4'h0
`define LRCF_SIZE_ATOMIC 4'h1
// Credit counter maximum and reset
`define LRCF_CREDIT_MAX 4'hf
`define LRCF_CREDIT_RESET 4'h0
// Host identifier for downstream
`define LRCF_HOST_UNIT 5'h00
// Credit packet bit positions
`define LRCF_CR_IO_BIT 7
`endif

/* core/lrcf_link_core.v */
// Response framing, stream tagging and credit flow for one link node
// How it works
// (RL1) Response size holds doublewords in the data packet minus one.
// (RL2) Doubleword reads copy request size; byte reads answer size zero.
// (RL3) Atomic read-modify-write responses carry size one.
// (RL4) Failed reads still send all data elements with error flag set.
// (RL5) Error plus nonexistent-address forces all data bits to one.
// (RL6) Nonexistent-address flag driven only alongside the error flag.
// (RL7) Isochronous flag copied from request into every response.
// (RL8) Bridged peer responses also return the request isochronous flag.
// (RL9) Response source tag equals request source tag.
// (RL10) Command buffer freed when the target-done packet issues.
// (RL11) Each nonposted request gets exactly one response kind.
// (RL12) Upstream stream identity taken from unit identifier.
// (RL13) Downstream traffic is one single stream.
// (RL14) Three virtual channels with separate command and data credits.
// (RL15) Accepting requests and issuing responses have no request dependency.
// (RL16) Six receiver buffer types, data buffers of 64 bytes.
// (RL17) Link reset zeroes counters; receiver then advertises its buffers.
// (RL18) Sending decrements the counter; never send on a zero counter.
// (RL19) Freed receiver buffers returned in credit packets; counters increment.
// (RL20) Packet with data needs both command and data credit.
// (RL21) Responses and posted requests always accepted without dependency.
// (RL22) Credit packet bit 7 of bit-time 2 always driven zero.
// (RL23) Each credit field is two bits, releasing zero to three buffers.
// (RL24) Credit counters four bits or wider, saturating, not wrapping.
// (RL25) One counter per buffer type; data packets update both counters.
`timescale 1ns/10ps
`include "lrcf_regs.vh"
module lrcf_link_core #(
    parameter CW = 4,
    parameter DW = 32,
    parameter RX_BUFS = 4
)(
    input wire ref_clk,
    input wire rstn,
    input wire link_rstn,
    input wire req_valid,
    input wire [1:0] req_kind,
    input wire [3:0] req_size,
    input wire req_isoc,
    input wire [4:0] req_source_tag,
    input wire [4:0] req_unit_identifier,
    input wire req_upstream,
    input wire req_bridge_peer,
    input wire req_fail,
    input wire req_nonexistent,
    input wire [DW-1:0] rd_data,
    input wire tx_vc_valid,
    input wire [1:0] tx_vc,
    input wire tx_has_data,
    input wire tx_info,
    input wire cr_valid,
    input wire [7:0] cr_byte1,
    input wire [7:0] cr_byte2,
    input wire [5:0] rx_free,
    output reg resp_valid,
    output reg [5:0] resp_cmd,
    output reg [3:0] resp_size,
    output reg resp_error,
    output reg resp_nonexistent_address_flag,
    output reg resp_isoc,
    output reg resp_bridge,
    output reg [4:0] resp_source_tag,
    output reg [4:0] resp_unit_identifier,
    output reg [4:0] resp_stream,
    output reg [DW-1:0] resp_data,
    output reg resp_data_valid,
    output reg cmd_buf_free,
    output reg tx_grant,
    output reg [6*CW-1:0] credit_count,
    output reg cp_valid,
    output reg [7:0] cp_byte1,
    output reg [7:0] cp_byte2
);
    // Link reset passes two flip-flops
    reg lr_s1_reg;
    reg lr_s2_reg;
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lr_s1_reg <= 1'b0;
            lr_s2_reg <= 1'b0;
        end
        else
        begin
            lr_s1_reg <= link_rstn;
            lr_s2_reg <= lr_s1_reg;
        end
    end
    wire link_in_reset = ~lr_s2_reg;

    // Response framing
    reg [3:0] size_next;
    reg [5:0] cmd_next;
    reg has_data;
    always @*
    begin
        has_data = 1'b1;
        cmd_next = `LRCF_CMD_READ_RESP;
        size_next = req_size; // see (RL1) (RL2)
        case (req_kind)
            `LRCF_REQ_DWORD_READ: size_next = req_size; // see (RL2)
            `LRCF_REQ_BYTE_READ: size_next = `LRCF_SIZE_BYTE_READ; // see (RL2)
            `LRCF_REQ_ATOMIC: size_next = `LRCF_SIZE_ATOMIC; // see (RL3)
            `LRCF_REQ_WRITE:
            begin
                has_data = 1'b0; // see (RL11)
                cmd_next = `LRCF_CMD_TARGET_DONE;
                size_next = 4'h0;
            end
            default: size_next = req_size;
        endcase
    end

    // Data beats remaining for a read response, minus one
    reg [3:0] beats_reg;
    reg all_ones_reg;
    reg busy_reg;
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            resp_valid <= 1'b0;
            resp_cmd <= 6'h00;
            resp_size <= 4'h0;
            resp_error <= 1'b0;
            resp_nonexistent_address_flag <= 1'b0;
            resp_isoc <= 1'b0;
            resp_bridge <= 1'b0;
            resp_source_tag <= 5'h00;
            resp_unit_identifier <= 5'h00;
            resp_stream <= 5'h00;
            resp_data <= {DW{1'b0}};
            resp_data_valid <= 1'b0;
            cmd_buf_free <= 1'b0;
            beats_reg <= 4'h0;
            all_ones_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            resp_valid <= 1'b0;
            cmd_buf_free <= 1'b0;
            resp_data_valid <= 1'b0;
            if (req_valid && !busy_reg)
            begin
                // One response per request, never both kinds
                resp_valid <= 1'b1; // see (RL11) (RL15)
                resp_cmd <= cmd_next;
                resp_size <= size_next; // see (RL1)
                resp_error <= req_fail; // see (RL4)
                resp_nonexistent_address_flag <= req_fail & req_nonexistent; // see (RL6)
                resp_isoc <= req_isoc; // see (RL7) (RL8)
                resp_bridge <= req_bridge_peer;
                resp_source_tag <= req_source_tag; // see (RL9)
                resp_unit_identifier <= req_unit_identifier;
                resp_stream <= req_upstream ? req_unit_identifier
                    : `LRCF_HOST_UNIT; // see (RL12) (RL13)
                cmd_buf_free <= ~has_data; // see (RL10)
                busy_reg <= has_data;
                beats_reg <= size_next; // see (RL4)
                all_ones_reg <= req_fail & req_nonexistent; // see (RL5)
            end
            else if (busy_reg)
            begin
                // All beats are sent even on error
                resp_data_valid <= 1'b1; // see (RL4)
                resp_data <= all_ones_reg ? {DW{1'b1}} : rd_data; // see (RL5)
                if (beats_reg == 4'h0)
                begin
                    busy_reg <= 1'b0;
                    cmd_buf_free <= 1'b1;
                end
                else
                    beats_reg <= beats_reg - 4'h1;
            end
        end
    end

    // Transmit credit counters, one per buffer type
    wire [2:0] cmd_type = {tx_vc, 1'b0};
    wire [2:0] dat_type = {tx_vc, 1'b1};
    wire [CW-1:0] cmd_cnt = credit_count[cmd_type*CW +: CW];
    wire [CW-1:0] dat_cnt = credit_count[dat_type*CW +: CW];
    wire vc_ok = tx_vc != 2'd3;
    // Command credit must be nonzero
    wire cmd_ok = cmd_cnt != {CW{1'b0}}; // see (RL18)
    // Data credit needed only with a data packet
    wire dat_ok = !tx_has_data || dat_cnt != {CW{1'b0}}; // see (RL20)
    // Info packets take no credit and are never granted
    wire kind_ok = vc_ok && !tx_info; // see (RL18)
    wire can_send = kind_ok && !link_in_reset && cmd_ok && dat_ok;
    wire send = tx_vc_valid && can_send;
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1)
        begin : g_cnt
            // Pick this buffer type's two-bit release field
            reg [1:0] inc;
            always @*
            begin
                inc = 2'd0;
                if (cr_valid)
                begin
                    case (gi)
                        0: inc = cr_byte1[1:0]; // see (RL23)
                        1: inc = cr_byte1[3:2];
                        2: inc = cr_byte2[1:0];
                        3: inc = cr_byte2[3:2];
                        4: inc = cr_byte1[5:4];
                        5: inc = cr_byte1[7:6];
                        default: inc = 2'd0;
                    endcase
                end
            end
            wire dec = send && (gi == cmd_type || (tx_has_data && gi == dat_type)); // see (RL25)
            wire [CW:0] sum = {1'b0, credit_count[gi*CW +: CW]} + {{(CW-1){1'b0}}, inc}
                - {{CW{1'b0}}, dec};
            always @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                    credit_count[gi*CW +: CW] <= {CW{1'b0}};
                else if (link_in_reset)
                    credit_count[gi*CW +: CW] <= {CW{1'b0}}; // see (RL17)
                else if (sum[CW])
                    credit_count[gi*CW +: CW] <= {CW{1'b1}}; // see (RL24)
                else
                    credit_count[gi*CW +: CW] <= sum[CW-1:0]; // see (RL19) (RL25)
            end
        end
    endgenerate

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            tx_grant <= 1'b0;
        else
            tx_grant <= send; // see (RL14) (RL18)
    end

    // Receiver side credit return: six buffer types, up to three each packet
    reg [6*CW-1:0] owed_reg;
    reg [6*CW-1:0] owed_next;
    reg [11:0] rel;
    integer k;
    integer j;
    reg [CW-1:0] o;
    always @*
    begin
        owed_next = owed_reg;
        rel = 12'h000;
        o = {CW{1'b0}};
        for (k = 0; k < 6; k = k + 1)
        begin
            o = owed_reg[k*CW +: CW];
            rel[k*2 +: 2] = (o > 3) ? 2'd3 : o[1:0]; // see (RL23)
            owed_next[k*CW +: CW] = o - {{(CW-2){1'b0}}, rel[k*2 +: 2]}
                + {{(CW-1){1'b0}}, rx_free[k]}; // see (RL19) (RL16)
        end
    end
    reg adv_done_reg;
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            owed_reg <= {6*CW{1'b0}};
            adv_done_reg <= 1'b0;
            cp_valid <= 1'b0;
            cp_byte1 <= 8'h00;
            cp_byte2 <= 8'h00;
        end
        else if (link_in_reset)
        begin
            owed_reg <= {6*CW{1'b0}};
            adv_done_reg <= 1'b0;
            cp_valid <= 1'b0;
        end
        else if (!adv_done_reg)
        begin
            // Advertise all buffers after link reset releases
            for (j = 0; j < 6; j = j + 1)
                owed_reg[j*CW +: CW] <= RX_BUFS[CW-1:0]; // see (RL17) (RL16)
            adv_done_reg <= 1'b1;
            cp_valid <= 1'b0;
        end
        else
        begin
            owed_reg <= owed_next;
            cp_valid <= rel != 12'h000;
            cp_byte1 <= {rel[11:10], rel[9:8], rel[3:2], rel[1:0]};
            cp_byte2 <= {1'b0, 3'b000, rel[7:6], rel[5:4]}; // see (RL22)
        end
    end
    // Responses and posted traffic never wait on request issue; see (RL21)
endmodule // lrcf_link_core

/* testbench/lrcf_link_props.sv */
// Port assertions for the link response and credit flow block
`timescale 1ns/10ps
`include "lrcf_regs.vh"
module lrcf_link_props #(
    parameter CW = 4,
    parameter DW = 32
)(
    input wire ref_clk,
    input wire rstn,
    input wire req_valid,
    input wire [1:0] req_kind,
    input wire [3:0] req_size,
    input wire req_isoc,
    input wire [4:0] req_source_tag,
    input wire tx_vc_valid,
    input wire [1:0] tx_vc,
    input wire tx_info,
    input wire resp_valid,
    input wire [5:0] resp_cmd,
    input wire [3:0] resp_size,
    input wire resp_error,
    input wire resp_nonexistent_address_flag,
    input wire resp_isoc,
    input wire [4:0] resp_source_tag,
    input wire [DW-1:0] resp_data,
    input wire resp_data_valid,
    input wire tx_grant,
    input wire [6*CW-1:0] credit_count,
    input wire cp_valid,
    input wire [7:0] cp_byte2
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire req_ok = req_valid && !resp_valid && !resp_data_valid;
    a_size_copy: assert property (req_ok && req_kind == 2'h0 |=>
        resp_valid && resp_size == $past(req_size)) else $error("read size not copied");
    a_size_byte: assert property (req_ok && req_kind == 2'h1 |=>
        resp_valid && resp_size == 4'h0) else $error("byte read size not zero");
    a_size_atomic: assert property (req_ok && req_kind == 2'h2 |=>
        resp_valid && resp_size == 4'h1) else $error("atomic size not one");
    a_tag_isoc: assert property (req_ok |=> resp_source_tag == $past(req_source_tag)
        && resp_isoc == $past(req_isoc)) else $error("tag or isoc not copied");
    a_one_resp: assert property (resp_valid |-> $past(req_valid))
        else $error("response without request");
    a_read_data: assert property (resp_valid && resp_cmd == `LRCF_CMD_READ_RESP
        |=> resp_data_valid) else $error("read data missing");
    a_all_ones: assert property (resp_data_valid && resp_error
        && resp_nonexistent_address_flag |-> &resp_data) else $error("data not all ones");
    a_nxa_err: assert property (resp_valid && resp_nonexistent_address_flag
        |-> resp_error) else $error("nonexistent flag without error");
    a_cp_bit7: assert property (cp_valid |-> !cp_byte2[7])
        else $error("credit packet bit 7 set");
    a_zero_credit: assert property (tx_vc_valid && tx_vc != 2'h3
        && credit_count[2*tx_vc*CW +: CW] == 0 |=> !tx_grant) else $error("send on zero");
    a_info_grant: assert property (tx_info |=> !tx_grant)
        else $error("info packet granted");
endmodule // lrcf_link_props
bind lrcf_link_core lrcf_link_props #(.CW(CW), .DW(DW)) u_props (.*);

/* testbench/lrcf_peer.sv */
// Far link node model returning credit packets
`timescale 1ns/10ps
module lrcf_peer (
    input wire ref_clk,
    input wire rstn,
    input wire go,
    input wire [1:0] n,
    output reg cr_valid,
    output reg [7:0] cr_byte1,
    output reg [7:0] cr_byte2
);
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cr_valid <= 1'h0;
            cr_byte1 <= 8'h00;
            cr_byte2 <= 8'h00;
        end
        else
        begin
            cr_valid <= go;
            cr_byte1 <= go ? {4{n}} : ~cr_byte1;
            cr_byte2 <= go ? {4'h0, n, n} : ~cr_byte2;
        end
    end
endmodule // lrcf_peer

/* testbench/lrcf_link_core_tb.sv */
// Self-checking bench for the link response and credit flow block
`timescale 1ns/10ps
`include "lrcf_regs.vh"
module lrcf_link_core_tb;
    reg ref_clk = 1'h0, rstn = 1'h0, link_rstn = 1'h0, req_valid = 1'h0, req_isoc = 1'h0;
    reg req_upstream = 1'h0, req_bridge_peer = 1'h0, req_fail = 1'h0, req_nonexistent = 1'h0;
    reg tx_vc_valid = 1'h0, tx_has_data = 1'h0, tx_info = 1'h0, go = 1'h0;
    reg [1:0] req_kind = 2'h0, tx_vc = 2'h0, n = 2'h3;
    reg [3:0] req_size = 4'h0;
    reg [4:0] req_source_tag = 5'h00, req_unit_identifier = 5'h00;
    reg [5:0] rx_free = 6'h00;
    reg [31:0] rd_data = 32'h0, exp_d;
    wire resp_valid, resp_error, resp_nonexistent_address_flag, resp_isoc, resp_bridge;
    wire resp_data_valid, cmd_buf_free, tx_grant, cp_valid, cr_valid;
    wire [5:0] resp_cmd;
    wire [3:0] resp_size;
    wire [4:0] resp_source_tag, resp_unit_identifier, resp_stream;
    wire [31:0] resp_data;
    wire [23:0] credit_count;
    wire [7:0] cp_byte1, cp_byte2, cr_byte1, cr_byte2;
    integer err_count = 0, n_tests = 0, seed = 2, cyc = 0, i, k, g, beats = 0, cp_sum = 0;
    lrcf_link_core u_dut (.*);
    lrcf_peer u_peer (.*);
    always #20 ref_clk = ~ref_clk;
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task tick(input integer c);
    begin
        repeat (c) @(posedge ref_clk);
        #1;
    end
    endtask
    task complete_run;
    begin
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task send(input [1:0] vc, input dat, input info, input integer exp);
    begin
        {tx_vc, tx_has_data, tx_info, tx_vc_valid} = {vc, dat, info, 1'h1};
        tick(1);
        tx_vc_valid = 1'h0;
        g = 0;
        repeat (3)
        begin
            g = g | tx_grant;
            tick(1);
        end
        chk(g, exp);
    end
    endtask
    function [3:0] exp_size(input [1:0] kd, input [3:0] sz);
        exp_size = kd == 2'h1 ? 4'h0 : kd == 2'h2 ? 4'h1 : sz;
    endfunction
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        cp_sum = cp_sum + (cp_valid ? cp_byte1[1:0] : 0);
        beats = beats + resp_data_valid;
        if (resp_data_valid)
            chk(resp_data, exp_d);
        if (cyc == 3000)
        begin
            err_count = err_count + 1;
            complete_run;
        end
    end
    initial
    begin
        tick(2);
        rstn = 1'h1;
        send(2'h1, 1'h0, 1'h0, 0);
        link_rstn = 1'h1;
        tick(10);
        chk(credit_count, 24'h0);
        chk(cp_sum, 4);
        send(2'h0, 1'h1, 1'h0, 0);
        for (i = 0; i < 6; i = i + 1)
        begin
            go = 1'h1;
            tick(1);
            go = 1'h0;
            tick(1);
        end
        chk(credit_count, 24'hffffff);
        send(2'h2, 1'h1, 1'h0, 1);
        chk(credit_count[23:16], 8'hee);
        send(2'h0, 1'h0, 1'h1, 0);
        send(2'h3, 1'h0, 1'h0, 0);
        rx_free = 6'h01;
        tick(1);
        rx_free = 6'h00;
        tick(4);
        chk(cp_sum, 5);
        $display("credit test done");
        for (i = 0; i < 16; i = i + 1)
        begin
            req_kind = i;
            {req_size, req_isoc, req_source_tag, req_upstream} = $random(seed);
            {req_unit_identifier, req_bridge_peer, req_nonexistent} = $random(seed);
            req_fail = i > 7 ? 1'h1 : $random(seed);
            req_nonexistent = req_nonexistent & req_fail;
            rd_data = $random(seed);
            exp_d = req_nonexistent ? 32'hffffffff : rd_data;
            beats = 0;
            req_valid = 1'h1;
            tick(1);
            req_valid = 1'h0;
            k = 0;
            while (resp_valid !== 1'h1 && k < 4)
            begin
                tick(1);
                k = k + 1;
            end
            chk(resp_cmd, i % 4 == 3 ? `LRCF_CMD_TARGET_DONE : `LRCF_CMD_READ_RESP);
            chk(resp_size, i % 4 == 3 ? 4'h0 : exp_size(req_kind, req_size));
            chk({resp_error, resp_nonexistent_address_flag, resp_isoc, resp_source_tag},
                {req_fail, req_nonexistent, req_isoc, req_source_tag});
            chk(resp_stream, req_upstream ? req_unit_identifier : 5'h00);
            tick(20);
            chk(beats, i % 4 == 3 ? 0 : exp_size(req_kind, req_size) + 1);
        end
        $display("response test done");
        complete_run;
    end
endmodule // lrcf_link_core_tb
